// ===== hdl/mupcm_top.sv
`timescale 1ns/1ps
module mupcm_top
   import mupcm_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic mclk,
   input wire logic rcv_clk,
   input wire logic rcv_frame_strobe,
   input wire logic rcv_data,
   input wire logic rcv_sig_frame,
   input wire logic rcv_sig_sel,
   input wire logic tx_clk,
   input wire logic transmit_frame_strobe,
   input wire logic tx_sig_frame,
   input wire logic tx_sig_sel,
   input wire logic [1:0] signalling_bit_pair_in,
   input wire logic comp_above,
   output logic tx_data,
   output logic tx_data_oe,
   output logic sample_hold,
   output logic [LIN_BITS-1:0] enc_dac,
   output logic [MSB_BITS-1:0] dec_msb,
   output logic [LSB_BITS-1:0] dec_lsb,
   output logic [1:0] signalling_bit_pair_out,
   output logic dec_busy
);

   // Expander: biased segment shift, sign-magnitude result
   function automatic logic [LIN_BITS-1:0] mupcm_expand(
      input logic [7:0] code,
      input logic half
   );
      logic [4:0] v;
      logic [13:0] m;
      v = half ? {code[3:1], 2'b01} : {code[3:0], 1'b0};
      m = (14'(v) + 14'(MU_BIAS)) << code[6:4];
      m = m - 14'(MU_BIAS);
      return {~code[7], m[12:1]};
   endfunction : mupcm_expand

   // Pins from other clocks; only sync_q and sync_prev are read by logic
   logic [SYNC_W-1:0] sync_raw, sync_meta, sync_q, sync_prev;
   logic rx_done_tgl;
   logic mclk_tick, tx_clk_rise, tx_stb_rise, rx_event, comp;

   // 25 MHz sampling resolves bit clocks up to 2.1 MHz
   assign sync_raw = {rx_done_tgl, comp_above, signalling_bit_pair_in,
                      tx_sig_sel, tx_sig_frame, transmit_frame_strobe,
                      tx_clk, mclk};

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sync_meta <= '0;
         sync_q <= '0;
         sync_prev <= '0;
      end else begin
         sync_meta <= sync_raw;
         sync_q <= sync_meta;
         sync_prev <= sync_q;
      end
   end

   // Sequencer time base is the partner's master clock
   assign mclk_tick = sync_q[SY_MCLK] && !sync_prev[SY_MCLK];
   assign tx_clk_rise = sync_q[SY_TXCLK] && !sync_prev[SY_TXCLK];
   assign tx_stb_rise = sync_q[SY_TXSTB] && !sync_prev[SY_TXSTB];
   assign rx_event = sync_q[SY_RXTGL] ^ sync_prev[SY_RXTGL];
   assign comp = sync_q[SY_COMP];

   // Receive link, on its own clock
   logic [WORD_BITS-1:0] rx_word;
   logic rx_word_sig, rx_word_sel;

   mupcm_rx_port u_rx (
      .rcv_clk(rcv_clk),
      .rst_n(rst_n),
      .rcv_frame_strobe(rcv_frame_strobe),
      .rcv_data(rcv_data),
      .rcv_sig_frame(rcv_sig_frame),
      .rcv_sig_sel(rcv_sig_sel),
      .word(rx_word),
      .word_sig(rx_word_sig),
      .word_sel(rx_word_sel),
      .done_tgl(rx_done_tgl)
   );

   // Encoded words wait here until their transmit frame
   logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
   logic [WORD_BITS-1:0] fifo_in_data, fifo_out_data;

   mupcm_fifo #(
      .WIDTH(WORD_BITS),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in_data),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );

   // Conversion clock divider, frozen during a decode interruption
   mupcm_dec_t dec_state, next_dec_state;
   logic [SAR_DIV_W-1:0] sar_div, next_sar_div;
   logic sar_clk, sar_step, hold;

   assign hold = (dec_state == DEC_HOLD);
   assign sar_clk = (sar_div >= SAR_DIV_W'(SAR_HALF_TICKS));
   assign sar_step = mclk_tick && !hold
                     && sar_div == SAR_DIV_W'(SAR_DIV_TICKS - 1);

   always_comb begin
      next_sar_div = sar_div;
      if (mclk_tick && !hold) begin
         next_sar_div = sar_step ? '0 : sar_div + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sar_div <= '0;
      end else begin
         sar_div <= next_sar_div;
      end
   end

   // Encoder: sample, then successive approximation
   mupcm_enc_t enc_state, next_enc_state;
   logic [SAMPLE_CNT_W-1:0] enc_cnt, next_enc_cnt;
   logic [2:0] enc_bit, next_enc_bit;
   logic [WORD_BITS-1:0] enc_code, next_enc_code, enc_trial, enc_kept;
   logic [LIN_BITS-1:0] next_enc_dac;
   logic enc_pend, next_enc_pend, next_sample_hold, keep;

   assign enc_trial = enc_code | (8'h01 << enc_bit);
   // Sign step keeps on positive input; magnitude on sign-matched compare
   assign keep = (enc_bit == 3'h7) ? comp : (comp == enc_code[7]);
   assign enc_kept = keep ? enc_trial : enc_code;
   assign fifo_in_valid = (enc_state == ENC_PUSH);
   // Line sign is 1 for positive; only magnitude bits are inverted
   assign fifo_in_data = {enc_code[7], ~enc_code[WORD_BITS-2:0]};

   always_comb begin
      next_enc_state = enc_state;
      next_enc_cnt = enc_cnt;
      next_enc_bit = enc_bit;
      next_enc_code = enc_code;
      next_enc_dac = enc_dac;
      next_sample_hold = sample_hold;
      next_enc_pend = enc_pend || tx_stb_rise;
      if (!hold) begin
         case (enc_state)
            ENC_IDLE: begin
               // A full buffer stalls the next sample
               if (enc_pend && fifo_in_ready) begin
                  next_enc_state = ENC_SAMPLE;
                  next_enc_cnt = '0;
                  next_sample_hold = 1'b1;
                  next_enc_pend = tx_stb_rise;
               end
            end
            ENC_SAMPLE: begin
               if (enc_cnt != SAMPLE_CNT_W'(SAMPLE_TICKS - 1)) begin
                  if (mclk_tick) begin
                     next_enc_cnt = enc_cnt + 1'b1;
                  end
               end else if (sar_step) begin
                  next_sample_hold = 1'b0;
                  next_enc_state = ENC_CONVERT;
                  next_enc_bit = 3'h7;
                  next_enc_code = '0;
                  next_enc_dac = LIN_ZERO;
               end
            end
            ENC_CONVERT: begin
               if (sar_step) begin
                  next_enc_code = enc_kept;
                  if (enc_bit == 3'h0) begin
                     next_enc_state = ENC_PUSH;
                  end else begin
                     next_enc_bit = enc_bit - 1'b1;
                     next_enc_dac = mupcm_expand(
                        enc_kept | (8'h01 << (enc_bit - 1'b1)), 1'b0);
                  end
               end
            end
            ENC_PUSH: begin
               if (fifo_in_ready) begin
                  next_enc_state = ENC_IDLE;
               end
            end
            default: next_enc_state = ENC_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         enc_state <= ENC_IDLE;
         enc_cnt <= '0;
         enc_bit <= '0;
         enc_code <= '0;
         enc_dac <= LIN_ZERO;
         sample_hold <= 1'b0;
         enc_pend <= 1'b0;
      end else begin
         enc_state <= next_enc_state;
         enc_cnt <= next_enc_cnt;
         enc_bit <= next_enc_bit;
         enc_code <= next_enc_code;
         enc_dac <= next_enc_dac;
         sample_hold <= next_sample_hold;
         enc_pend <= next_enc_pend;
      end
   end

   // Decoder: interrupt encoding, expand, load latch
   logic [DEC_CNT_W-1:0] dec_cnt, next_dec_cnt;
   logic [WORD_BITS-1:0] dec_word, next_dec_word;
   logic [LIN_BITS-1:0] dec_lin, next_dec_lin;
   logic [1:0] next_sig_out;
   logic dec_sig, next_dec_sig, dec_done;

   assign dec_done = hold && dec_cnt == DEC_CNT_W'(DEC_HOLD_CYC - 1);

   always_comb begin
      next_dec_state = dec_state;
      next_dec_cnt = dec_cnt;
      next_dec_word = dec_word;
      next_dec_sig = dec_sig;
      next_dec_lin = dec_lin;
      next_sig_out = signalling_bit_pair_out;
      if (rx_event) begin
         next_dec_word = rx_word;
         next_dec_sig = rx_word_sig;
         if (rx_word_sig) begin
            next_sig_out[rx_word_sel] = rx_word[0];
         end
      end
      case (dec_state)
         DEC_IDLE: begin
            if (rx_event) begin
               next_dec_state = DEC_WAIT;
            end
         end
         DEC_WAIT: begin
            if (!sar_clk) begin
               next_dec_state = DEC_HOLD;
               next_dec_cnt = '0;
            end
         end
         DEC_HOLD: begin
            if (dec_done) begin
               next_dec_lin = mupcm_expand(
                  {dec_word[7], ~dec_word[WORD_BITS-2:0]},
                  dec_sig);
               next_dec_state = rx_event ? DEC_WAIT : DEC_IDLE;
            end else begin
               next_dec_cnt = dec_cnt + 1'b1;
            end
         end
         default: next_dec_state = DEC_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         dec_state <= DEC_IDLE;
         dec_cnt <= '0;
         dec_word <= IDLE_CODE;
         dec_sig <= 1'b0;
         dec_lin <= LIN_ZERO;
         signalling_bit_pair_out <= 2'h0;
      end else begin
         dec_state <= next_dec_state;
         dec_cnt <= next_dec_cnt;
         dec_word <= next_dec_word;
         dec_sig <= next_dec_sig;
         dec_lin <= next_dec_lin;
         signalling_bit_pair_out <= next_sig_out;
      end
   end

   assign dec_msb = dec_lin[LIN_BITS-1:LSB_BITS];
   assign dec_lsb = dec_lin[LSB_BITS-1:0];
   assign dec_busy = hold;

   // Transmit port: load at strobe rise, shift on tx clock rises
   logic [WORD_BITS-1:0] tx_buf, next_tx_buf, tx_word;
   logic [BIT_CNT_W-1:0] tx_cnt, next_tx_cnt;
   logic next_tx_oe;

   assign fifo_out_ready = tx_stb_rise;
   assign tx_data = tx_buf[WORD_BITS-1];

   always_comb begin
      tx_word = fifo_out_valid ? fifo_out_data : IDLE_CODE;
      if (sync_q[SY_TXSF]) begin
         tx_word[0] = sync_q[SY_SIG + 32'(sync_q[SY_TXSEL])];
      end
      next_tx_buf = tx_buf;
      next_tx_cnt = tx_cnt;
      next_tx_oe = tx_data_oe;
      if (!sync_q[SY_TXSTB]) begin
         next_tx_oe = 1'b0;
         next_tx_cnt = '0;
      end else if (tx_stb_rise) begin
         next_tx_buf = tx_word;
         next_tx_oe = 1'b1;
         next_tx_cnt = BIT_CNT_W'(1);
      end else if (tx_clk_rise && tx_cnt != BIT_CNT_W'(WORD_BITS)) begin
         next_tx_buf = {tx_buf[WORD_BITS-2:0], 1'b0};
         next_tx_cnt = tx_cnt + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tx_buf <= IDLE_CODE;
         tx_cnt <= '0;
         tx_data_oe <= 1'b0;
      end else begin
         tx_buf <= next_tx_buf;
         tx_cnt <= next_tx_cnt;
         tx_data_oe <= next_tx_oe;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_latch_hold;
      !dec_done |=> $stable(dec_lin);
   endproperty
   a_latch_hold: assert property (p_latch_hold)
      else $error("receive latch changed outside a load");

   property p_dec_start_low;
      (dec_state == DEC_WAIT && next_dec_state == DEC_HOLD) |-> !sar_clk;
   endproperty
   a_dec_start_low: assert property (p_dec_start_low)
      else $error("decode interruption began with conversion clock high");

   property p_suspend;
      hold |=> $stable(sar_div) && $stable(enc_code) && $stable(enc_state);
   endproperty
   a_suspend: assert property (p_suspend)
      else $error("encoder advanced during decode interruption");

   property p_hold_len;
      (dec_state == DEC_WAIT && next_dec_state == DEC_HOLD)
         |=> hold [*8] ##0 dec_cnt == 7'h07;
   endproperty
   a_hold_len: assert property (p_hold_len)
      else $error("decode interruption counter misbehaved");

   property p_sar_step;
      (enc_state == ENC_CONVERT && sar_step && enc_bit != 3'h0)
         |=> enc_bit == $past(enc_bit) - 1'b1
             && enc_state == ENC_CONVERT;
   endproperty
   a_sar_step: assert property (p_sar_step)
      else $error("conversion did not resolve one bit per step");

   property p_push;
      (enc_state == ENC_CONVERT && sar_step && enc_bit == 3'h0)
         |=> enc_state == ENC_PUSH ##1 enc_state == ENC_IDLE;
   endproperty
   a_push: assert property (p_push)
      else $error("finished code not loaded into transmit buffer");

   property p_tx_oe;
      tx_data_oe |-> sync_prev[SY_TXSTB];
   endproperty
   a_tx_oe: assert property (p_tx_oe)
      else $error("transmit data driven outside the frame strobe");

   property p_tx_sig;
      (tx_stb_rise && sync_q[SY_TXSF])
         |=> tx_buf[0] == $past(sync_q[SY_SIG + 32'(sync_q[SY_TXSEL])]);
   endproperty
   a_tx_sig: assert property (p_tx_sig)
      else $error("signalling bit not inserted in transmit word");

   property p_rx_sig;
      (rx_event && rx_word_sig)
         |=> signalling_bit_pair_out[$past(rx_word_sel)] == $past(rx_word[0]);
   endproperty
   a_rx_sig: assert property (p_rx_sig)
      else $error("received signalling bit not latched");

endmodule : mupcm_top

// ===== hdl/mupcm_pkg.sv
package mupcm_pkg;

   // Clock figures
   localparam int CLK_HZ = 25_000_000;
   localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;

   // Decode interruption, least time, rounded up to clk cycles
   localparam int DEC_HOLD_NS = 5000;
   localparam int DEC_HOLD_CYC =
      (DEC_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DEC_CNT_W = 7;

   // Sequencer timing in master clock ticks
   localparam int SAR_DIV_TICKS = 8;
   localparam int SAR_HALF_TICKS = 4;
   localparam int SAR_DIV_W = 3;
   localparam int SAMPLE_TICKS = 40;
   localparam int SAMPLE_CNT_W = 6;

   // Word and code layout
   localparam int WORD_BITS = 8;
   localparam int BIT_CNT_W = 4;
   localparam int LIN_BITS = 13;
   localparam int MSB_BITS = 7;
   localparam int LSB_BITS = 6;
   localparam int MU_BIAS = 33;
   localparam int FIFO_DEPTH = 16;
   localparam logic [7:0] IDLE_CODE = 8'hFF;
   localparam logic [LIN_BITS-1:0] LIN_ZERO = 13'h0000;

   // Positions in the synchroniser vector
   localparam int SY_MCLK = 0;
   localparam int SY_TXCLK = 1;
   localparam int SY_TXSTB = 2;
   localparam int SY_TXSF = 3;
   localparam int SY_TXSEL = 4;
   localparam int SY_SIG = 5;
   localparam int SY_COMP = 7;
   localparam int SY_RXTGL = 8;
   localparam int SYNC_W = 9;

   typedef enum logic [1:0] {
      ENC_IDLE, ENC_SAMPLE, ENC_CONVERT, ENC_PUSH
   } mupcm_enc_t;

   typedef enum logic [1:0] {
      DEC_IDLE, DEC_WAIT, DEC_HOLD
   } mupcm_dec_t;

endpackage : mupcm_pkg

// ===== hdl/mupcm_fifo.sv
`timescale 1ns/1ps
module mupcm_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [AW:0] count, next_count;
   logic push, pop;

   assign in_ready = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
      next_count = count + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_count_track;
      (push && !pop) |=> count == $past(count) + 1'b1;
   endproperty
   a_count_track: assert property (p_count_track)
      else $error("fifo count did not follow a push");

endmodule : mupcm_fifo

// ===== hdl/mupcm_rx_port.sv
`timescale 1ns/1ps
module mupcm_rx_port
   import mupcm_pkg::*;
(
   input wire logic rcv_clk,
   input wire logic rst_n,
   input wire logic rcv_frame_strobe,
   input wire logic rcv_data,
   input wire logic rcv_sig_frame,
   input wire logic rcv_sig_sel,
   output logic [WORD_BITS-1:0] word,
   output logic word_sig,
   output logic word_sel,
   output logic done_tgl
);
   logic rst_meta, rst_sync_n;
   logic [WORD_BITS-1:0] shreg, next_shreg, next_word;
   logic [BIT_CNT_W-1:0] cnt, next_cnt;
   logic next_word_sig, next_word_sel, next_done_tgl;

   // Reset brought onto the link clock
   always_ff @(posedge rcv_clk) begin
      rst_meta <= rst_n;
      rst_sync_n <= rst_meta;
   end

   always_comb begin
      next_shreg = shreg;
      next_cnt = cnt;
      next_word = word;
      next_word_sig = word_sig;
      next_word_sel = word_sel;
      next_done_tgl = done_tgl;
      if (!rcv_frame_strobe) begin
         next_cnt = '0;
      end else if (cnt != BIT_CNT_W'(WORD_BITS)) begin
         next_shreg = {shreg[WORD_BITS-2:0], rcv_data};
         next_cnt = cnt + 1'b1;
         if (cnt == BIT_CNT_W'(WORD_BITS - 1)) begin
            // One word per frame; held until the eighth bit of the next frame
            next_word = {shreg[WORD_BITS-2:0], rcv_data};
            next_word_sig = rcv_sig_frame;
            next_word_sel = rcv_sig_sel;
            next_done_tgl = ~done_tgl;
         end
      end
   end

   always_ff @(posedge rcv_clk) begin
      if (!rst_sync_n) begin
         shreg <= '0;
         cnt <= '0;
         word <= IDLE_CODE;
         word_sig <= 1'b0;
         word_sel <= 1'b0;
         done_tgl <= 1'b0;
      end else begin
         shreg <= next_shreg;
         cnt <= next_cnt;
         word <= next_word;
         word_sig <= next_word_sig;
         word_sel <= next_word_sel;
         done_tgl <= next_done_tgl;
      end
   end

   default clocking cb @(posedge rcv_clk); endclocking
   default disable iff (!rst_sync_n);

   property p_shift_in;
      (rcv_frame_strobe && cnt < BIT_CNT_W'(WORD_BITS))
         |=> cnt == $past(cnt) + 1'b1 && shreg[0] == $past(rcv_data);
   endproperty
   a_shift_in: assert property (p_shift_in)
      else $error("receive bit not shifted while strobe high");

endmodule : mupcm_rx_port

// ===== bench/mupcm_far_end.sv
`timescale 1ns/1ps
module mupcm_far_end (
   output logic mclk,
   output logic rcv_clk,
   output logic rcv_frame_strobe,
   output logic rcv_data,
   output logic rcv_sig_frame,
   output logic rcv_sig_sel,
   output logic tx_clk,
   output logic transmit_frame_strobe,
   input wire logic tx_data,
   input wire logic tx_data_oe
);
   initial begin
      {mclk, rcv_clk, rcv_frame_strobe, rcv_data} = 4'h0;
      {rcv_sig_frame, rcv_sig_sel, tx_clk, transmit_frame_strobe} = 4'h0;
      // Link-side reset synchroniser needs edges across reset release
      repeat (20) begin
         #7.5 rcv_clk = 1'b1;
         #7.5 rcv_clk = 1'b0;
      end
   end

   always #250 mclk = ~mclk;

   // Link clock runs inside a frame, plus one closing edge after it
   task automatic send_rx(input logic [7:0] b, input int nbits,
      input logic sf, input logic sel);
      rcv_sig_frame = sf;
      rcv_sig_sel = sel;
      rcv_frame_strobe = 1'b1;
      for (int i = 0; i < nbits; i++) begin
         rcv_data = b[7 - i % 8];
         #7.5 rcv_clk = 1'b1;
         #7.5 rcv_clk = 1'b0;
      end
      rcv_frame_strobe = 1'b0;
      // Released line must not keep showing the last bit
      rcv_data = ~rcv_data;
      // One closing edge so the port sees the strobe low
      #7.5 rcv_clk = 1'b1;
      #7.5 rcv_clk = 1'b0;
   endtask : send_rx

   // Undriven bits come back unknown so a missing enable is caught
   task automatic recv_tx(output logic [7:0] w);
      transmit_frame_strobe = 1'b1;
      for (int i = 0; i < 9; i++) begin
         tx_clk = 1'b1;
         #240 tx_clk = 1'b0;
         if (i < 8) begin
            w[7 - i] = tx_data_oe ? tx_data : 1'bx;
         end
         #240;
      end
      transmit_frame_strobe = 1'b0;
   endtask : recv_tx
endmodule : mupcm_far_end

// ===== bench/mupcm_top_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) check(nm, 13'(e), 13'(g))
module mupcm_top_tb;
   import mupcm_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic comp_above = 1'b0;
   logic tx_sig_frame = 1'b0;
   logic tx_sig_sel = 1'b0;
   logic [1:0] sp_in = 2'h0;
   logic mclk, rcv_clk, rcv_frame_strobe, rcv_data, rcv_sig_frame;
   logic rcv_sig_sel, tx_clk, transmit_frame_strobe, tx_data, tx_data_oe;
   logic sample_hold, dec_busy;
   logic [LIN_BITS-1:0] enc_dac;
   logic [MSB_BITS-1:0] dec_msb;
   logic [LSB_BITS-1:0] dec_lsb;
   logic [1:0] sp_out;
   int mismatches = 0;
   int n_compared = 0;
   integer seed = 32'h76F2C632;
   int x = 0;

   always #20 clk = ~clk;

   // Ideal comparator against the sign-magnitude encode DAC
   always @(negedge clk) begin
      comp_above <= x > (enc_dac[12] ? -int'(enc_dac[11:0])
         : int'(enc_dac[11:0]));
   end

   mupcm_top u_dut (
      .clk(clk),
      .rst_n(rst_n),
      .mclk(mclk),
      .rcv_clk(rcv_clk),
      .rcv_frame_strobe(rcv_frame_strobe),
      .rcv_data(rcv_data),
      .rcv_sig_frame(rcv_sig_frame),
      .rcv_sig_sel(rcv_sig_sel),
      .tx_clk(tx_clk),
      .transmit_frame_strobe(transmit_frame_strobe),
      .tx_sig_frame(tx_sig_frame),
      .tx_sig_sel(tx_sig_sel),
      .signalling_bit_pair_in(sp_in),
      .comp_above(comp_above),
      .tx_data(tx_data),
      .tx_data_oe(tx_data_oe),
      .sample_hold(sample_hold),
      .enc_dac(enc_dac),
      .dec_msb(dec_msb),
      .dec_lsb(dec_lsb),
      .signalling_bit_pair_out(sp_out),
      .dec_busy(dec_busy)
   );

   mupcm_far_end pm (
      .mclk(mclk),
      .rcv_clk(rcv_clk),
      .rcv_frame_strobe(rcv_frame_strobe),
      .rcv_data(rcv_data),
      .rcv_sig_frame(rcv_sig_frame),
      .rcv_sig_sel(rcv_sig_sel),
      .tx_clk(tx_clk),
      .transmit_frame_strobe(transmit_frame_strobe),
      .tx_data(tx_data),
      .tx_data_oe(tx_data_oe)
   );

   function automatic logic [12:0] expand(input logic [7:0] b,
      input logic half);
      logic [7:0] c;
      int st;
      int m;
      c = ~b;
      st = half ? 2 * (c[3:0] & 4'hE) + 1 : 2 * c[3:0];
      m = ((st + MU_BIAS) << c[6:4]) - MU_BIAS;
      return {c[7], 12'(m >> 1)};
   endfunction : expand

   task automatic check(input string nm, input logic [12:0] e,
      input logic [12:0] g);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask : check

   task automatic stop_test;
      if (mismatches == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : stop_test

   initial begin
      #3_000_000;
      mismatches++;
      stop_test();
   end

   initial begin
      logic [7:0] b, w, e, m;
      logic rsf, rsel;
      logic [1:0] exp_sp;
      int px, n;
      realtime t0;
      exp_sp = 2'h0;
      px = 0;
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      `CHK("oe idle", 1'b0, tx_data_oe);
      for (int f = 0; f < 12; f++) begin
         @(negedge clk);
         t0 = $realtime;
         // Frames 1 and 2 drive the encoder to full scale
         x = $random(seed) % 3800;
         x = f == 1 ? 5000 : f == 2 ? -5000 : x + (x < 0 ? -200 : 200);
         b = 8'($random(seed));
         {rsf, rsel, tx_sig_frame, tx_sig_sel, sp_in} = 6'($random(seed));
         fork
            begin
               pm.recv_tx(w);
               // Word is out while the encoder still samples
               `CHK("sampling", 1'b1, sample_hold);
            end
            begin
               // Lands at the end of sampling, before conversion starts
               #20000;
               pm.send_rx(b, f == 4 ? 9 : 8, rsf, rsel);
            end
         join
         e = f == 0 ? 8'hFF : px >= 0 ? 8'h80 : 8'h00;
         m = (f == 0 || f == 2 || f == 3) ? 8'hFF : 8'h80;
         if (tx_sig_frame) begin
            e[0] = sp_in[tx_sig_sel];
            m[0] = 1'b1;
         end
         `CHK("tx word", e & m, w & m);
         n = 0;
         while (!dec_busy && n < 300) begin
            @(negedge clk);
            n++;
         end
         `CHK("busy", 1'b1, dec_busy);
         while (dec_busy && n < 600) begin
            @(negedge clk);
            n++;
         end
         if (n >= 600) begin
            mismatches++;
            stop_test();
         end
         repeat (2) @(negedge clk);
         if (rsf) begin
            exp_sp[rsel] = b[0];
         end
         `CHK("sig out", exp_sp, sp_out);
         `CHK("latch", expand(b, rsf), {dec_msb, dec_lsb});
         `CHK("split", expand(b, rsf) >> 6, dec_msb);
         px = x;
         #(125000 - ($realtime - t0));
         `CHK("latch hold", expand(b, rsf), {dec_msb, dec_lsb});
         `CHK("held", 1'b0, sample_hold);
         `CHK("dac sign", x < 0, enc_dac[12]);
      end
      stop_test();
   end
endmodule : mupcm_top_tb
